// [pkg/word_right_load_pkg.sv]
package word_right_load_pkg;

  // ------------------------------------------------------------
  // operation kinds
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    load_word_right_op = 2'h0,
    load_word_right_user_op = 2'h1,
    pc_relative_word_load = 2'h2
  } op_kind_type;

  // ------------------------------------------------------------
  // sequencer states, one-hot
  // ------------------------------------------------------------
  typedef enum logic [2:0] {
    st_idle = 3'h1,
    st_xlat = 3'h2,
    st_read = 3'h4
  } state_type;

  // ------------------------------------------------------------
  // segment access modes reported by translation
  // ------------------------------------------------------------
  localparam logic [2:0] SEG_MODE_KERNEL_ONLY = 3'h0;
  localparam logic [2:0] SEG_MODE_MAPPED_USER_KERNEL = 3'h1;
  localparam logic [2:0] SEG_MODE_UNMAPPED_USER = 3'h2;
  localparam logic [2:0] SEG_MODE_MAPPED_USER_SUPER = 3'h3;

  // ------------------------------------------------------------
  // exception codes
  // ------------------------------------------------------------
  localparam logic [3:0] EXC_NONE = 4'h0;
  localparam logic [3:0] EXC_TLB_REFILL = 4'h1;
  localparam logic [3:0] EXC_TLB_INVALID = 4'h2;
  localparam logic [3:0] EXC_BUS_ERROR = 4'h3;
  localparam logic [3:0] EXC_ADDRESS_ERROR = 4'h4;
  localparam logic [3:0] EXC_WATCH = 4'h5;
  localparam logic [3:0] EXC_RESERVED_INSN = 4'h6;
  localparam logic [3:0] EXC_COP_UNUSABLE = 4'h7;

  // ------------------------------------------------------------
  // widths and field positions
  // ------------------------------------------------------------
  localparam int WORD_W = 32;
  localparam int REG_W = 64;
  localparam int PLAIN_IMM_W = 16;
  localparam int USER_IMM_W = 9;
  localparam int PCREL_OFS_W = 19;
  localparam int PCREL_SHIFT = 2;
  localparam int WATCH_ADDR_LSB = 3;
  localparam int WATCH_INSN_BIT = 2;
  localparam int WATCH_LOAD_BIT = 1;
  localparam int WATCH_STORE_BIT = 0;

  // ------------------------------------------------------------
  // reset values
  // ------------------------------------------------------------
  localparam logic [31:0] RESET_WORD = 32'h0000_0000;
  localparam logic [63:0] RESET_REG = 64'h0000_0000_0000_0000;
  localparam logic [4:0] RESET_INDEX = 5'h00;
  localparam logic [1:0] RESET_BYTE = 2'h0;

endpackage : word_right_load_pkg

// [rtl/right_byte_merge.sv]
`timescale 1ns/1ps

module right_byte_merge
  import word_right_load_pkg::*;
(
  input wire logic [31:0] mem_word,
  input wire logic [63:0] dest_old,
  input wire logic [1:0] byte_index,
  output logic [63:0] merged
);

  // ------------------------------------------------------------
  // lane selection
  // ------------------------------------------------------------
  logic [31:0] shifted;
  logic [31:0] low_word;

  // memory bytes from byte_index upward land at the bottom
  assign shifted = mem_word >> {byte_index, 3'h0};

  genvar lane;
  generate
    for (lane = 0; lane < 4; lane = lane + 1) begin : g_lane
      localparam logic [2:0] LANE_NUM = 3'(lane);
      logic take;
      assign take = (LANE_NUM + {1'b0, byte_index}) < 3'h4;
      assign low_word[8*lane +: 8] = take ? shifted[8*lane +: 8] : dest_old[8*lane +: 8];
    end
  endgenerate

  // ------------------------------------------------------------
  // upper half
  // ------------------------------------------------------------
  // top byte written only for index 0; then upper bits copy bit 31
  assign merged[31:0] = low_word;
  assign merged[63:32] = (byte_index == 2'h0) ? {32{low_word[31]}} : dest_old[63:32];

endmodule : right_byte_merge

// [rtl/unaligned_word_right_load.sv]
`timescale 1ns/1ps


module unaligned_word_right_load
  import word_right_load_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic op_valid,
  input wire logic [1:0] op_kind,
  input wire logic [31:0] base_value,
  input wire logic [15:0] imm_offset,
  input wire logic [31:0] pc_value,
  input wire logic [18:0] pc_offset,
  input wire logic [4:0] dest_reg_field,
  input wire logic [63:0] dest_old,
  input wire logic core_big_order,
  input wire logic swap_byte_order_flag,
  input wire logic memory_big_order,
  input wire logic extended_user_access_cfg,
  input wire logic cop0_access_en,
  input wire logic release6_core,
  input wire logic [31:0] watch_low_reg,
  input wire logic xlat_done,
  input wire logic [31:0] xlat_paddr,
  input wire logic [2:0] xlat_seg_mode,
  input wire logic xlat_refill,
  input wire logic xlat_invalid,
  input wire logic xlat_addr_err,
  input wire logic mem_done,
  input wire logic [31:0] mem_word,
  input wire logic mem_bus_err,
  output logic op_ready,
  output logic xlat_req,
  output logic [31:0] xlat_virt_addr,
  output logic xlat_user_map,
  output logic xlat_is_data,
  output logic mem_req,
  output logic [31:0] mem_paddr,
  output logic [1:0] mem_byte_index,
  output logic wb_valid,
  output logic [4:0] wb_index,
  output logic [63:0] wb_data,
  output logic exc_valid,
  output logic [3:0] exc_code
);

  // ------------------------------------------------------------
  // state record
  // ------------------------------------------------------------
  typedef struct packed {
    state_type fsm;
    op_kind_type op;
    logic [63:0] dest_old;
    logic [1:0] byte_index;
    logic op_ready;
    logic xlat_req;
    logic [31:0] xlat_virt_addr;
    logic xlat_user_map;
    logic xlat_is_data;
    logic mem_req;
    logic [31:0] mem_paddr;
    logic [1:0] mem_byte_index;
    logic wb_valid;
    logic [4:0] wb_index;
    logic [63:0] wb_data;
    logic exc_valid;
    logic [3:0] exc_code;
  } regs_type;

  regs_type r;
  regs_type next_r;

  // ------------------------------------------------------------
  // address formation
  // ------------------------------------------------------------
  logic [31:0] plain_ext;
  logic [31:0] user_ext;
  logic [31:0] pcrel_ext;
  logic [31:0] new_virt_addr;
  op_kind_type new_op;

  assign new_op = op_kind_type'(op_kind);
  assign plain_ext = {{(WORD_W - PLAIN_IMM_W){imm_offset[PLAIN_IMM_W-1]}}, imm_offset};
  assign user_ext = {{(WORD_W - USER_IMM_W){imm_offset[USER_IMM_W-1]}},
                     imm_offset[USER_IMM_W-1:0]};
  assign pcrel_ext = {{(WORD_W - PCREL_OFS_W - PCREL_SHIFT){pc_offset[PCREL_OFS_W-1]}},
                      pc_offset, 2'h0};

  always_comb begin
    unique case (new_op)
      load_word_right_op: new_virt_addr = base_value + plain_ext;
      load_word_right_user_op: new_virt_addr = base_value + user_ext;
      pc_relative_word_load: new_virt_addr = pc_value + pcrel_ext;
      default: new_virt_addr = base_value + plain_ext;
    endcase
  end

  // ------------------------------------------------------------
  // decode checks at issue
  // ------------------------------------------------------------
  logic is_partial;
  logic is_user;
  logic bad_opcode;
  logic no_cop0;

  assign is_partial = (new_op == load_word_right_op) || (new_op == load_word_right_user_op);
  assign is_user = (new_op == load_word_right_user_op);
  // unknown op codes, the dropped family on a sixth-release core, the user variant without its config, pc-relative on older cores
  assign bad_opcode = (op_kind == 2'h3)
                    || (is_partial && release6_core)
                    || (is_user && !extended_user_access_cfg)
                    || ((new_op == pc_relative_word_load) && !release6_core);
  assign no_cop0 = is_user && !cop0_access_en;

  // ------------------------------------------------------------
  // translation result checks
  // ------------------------------------------------------------
  logic seg_user_ok;
  logic watch_hit;
  logic [1:0] phys_low;
  logic [1:0] new_byte_index;

  // user variant reaches only the three user-accessible segment modes
  assign seg_user_ok = (xlat_seg_mode == SEG_MODE_MAPPED_USER_KERNEL)
                     || (xlat_seg_mode == SEG_MODE_UNMAPPED_USER)
                     || (xlat_seg_mode == SEG_MODE_MAPPED_USER_SUPER);

  // every op of this block, pc-relative included, is a data reference
  assign watch_hit = watch_low_reg[WATCH_LOAD_BIT]
                   && (r.xlat_virt_addr[31:WATCH_ADDR_LSB] == watch_low_reg[31:WATCH_ADDR_LSB]);

  always_comb begin
    phys_low = xlat_paddr[1:0] ^ {2{swap_byte_order_flag}};
    if (!memory_big_order) begin
      phys_low = 2'h0;
    end
  end

  // pc-relative loads take the whole word; byte 0 selects all four lanes
  assign new_byte_index = (r.op == pc_relative_word_load) ? 2'h0
                        : (r.xlat_virt_addr[1:0] ^ {2{core_big_order}});

  // ------------------------------------------------------------
  // byte merge
  // ------------------------------------------------------------
  logic [63:0] merged;

  // left-load bytes already in dest_old are kept, so either order completes the word
  right_byte_merge u_merge (
    .mem_word(mem_word),
    .dest_old(r.dest_old),
    .byte_index(r.byte_index),
    .merged(merged)
  );

  // ------------------------------------------------------------
  // sequencer
  // ------------------------------------------------------------
  always_comb begin
    next_r = r;
    next_r.wb_valid = 1'b0;
    next_r.exc_valid = 1'b0;
    unique case (r.fsm)
      st_idle: begin
        if (op_valid) begin
          next_r.op_ready = 1'b0;
          next_r.op = new_op;
          next_r.dest_old = dest_old;
          next_r.wb_index = dest_reg_field;
          next_r.xlat_virt_addr = new_virt_addr;
          next_r.exc_code = EXC_NONE;
          if (bad_opcode) begin
            next_r.op_ready = 1'b1;
            next_r.exc_valid = 1'b1;
            next_r.exc_code = EXC_RESERVED_INSN;
          end else if (no_cop0) begin
            next_r.op_ready = 1'b1;
            next_r.exc_valid = 1'b1;
            next_r.exc_code = EXC_COP_UNUSABLE;
          end else begin
            next_r.xlat_req = 1'b1;
            next_r.xlat_is_data = 1'b1;
            next_r.xlat_user_map = 1'b0;
            next_r.fsm = st_xlat;
          end
        end
      end
      st_xlat: begin
        // user mapping is chosen once the segment mode is known
        next_r.xlat_user_map = (r.op == load_word_right_user_op)
                             && (xlat_seg_mode == SEG_MODE_MAPPED_USER_KERNEL);
        // faults rank refill, invalid, address, watch; any of them skips the read
        if (xlat_done) begin
          next_r.xlat_req = 1'b0;
          next_r.xlat_user_map = 1'b0;
          next_r.exc_valid = 1'b1;
          next_r.op_ready = 1'b1;
          next_r.fsm = st_idle;
          if (xlat_refill) begin
            next_r.exc_code = EXC_TLB_REFILL;
          end else if (xlat_invalid) begin
            next_r.exc_code = EXC_TLB_INVALID;
          end else if (xlat_addr_err
                       || ((r.op == load_word_right_user_op) && !seg_user_ok)) begin
            next_r.exc_code = EXC_ADDRESS_ERROR;
          end else if (watch_hit) begin
            next_r.exc_code = EXC_WATCH;
          end else begin
            // no alignment fault: any byte offset is a legal start
            next_r.exc_valid = 1'b0;
            next_r.op_ready = 1'b0;
            next_r.byte_index = new_byte_index;
            next_r.mem_byte_index = new_byte_index;
            next_r.mem_paddr = {xlat_paddr[31:2], phys_low};
            next_r.mem_req = 1'b1;
            next_r.fsm = st_read;
          end
        end
      end
      st_read: begin
        if (mem_done) begin
          next_r.mem_req = 1'b0;
          next_r.op_ready = 1'b1;
          next_r.fsm = st_idle;
          if (mem_bus_err) begin
            next_r.exc_valid = 1'b1;
            next_r.exc_code = EXC_BUS_ERROR;
          end else begin
            // mem_word is only valid at this edge, so the merge is taken now
            next_r.wb_valid = 1'b1;
            next_r.wb_data = merged;
          end
        end
      end
    endcase
  end

  // ------------------------------------------------------------
  // state register
  // ------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (rst) begin
      r.fsm <= st_idle;
      r.op <= load_word_right_op;
      r.dest_old <= RESET_REG;
      r.byte_index <= RESET_BYTE;
      r.op_ready <= 1'b1;
      r.xlat_req <= 1'b0;
      r.xlat_virt_addr <= RESET_WORD;
      r.xlat_user_map <= 1'b0;
      r.xlat_is_data <= 1'b0;
      r.mem_req <= 1'b0;
      r.mem_paddr <= RESET_WORD;
      r.mem_byte_index <= RESET_BYTE;
      r.wb_valid <= 1'b0;
      r.wb_index <= RESET_INDEX;
      r.wb_data <= RESET_REG;
      r.exc_valid <= 1'b0;
      r.exc_code <= EXC_NONE;
    end else begin
      r <= next_r;
    end
  end

  // ------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------
  assign op_ready = r.op_ready;
  assign xlat_req = r.xlat_req;
  assign xlat_virt_addr = r.xlat_virt_addr;
  assign xlat_user_map = r.xlat_user_map;
  assign xlat_is_data = r.xlat_is_data;
  assign mem_req = r.mem_req;
  assign mem_paddr = r.mem_paddr;
  assign mem_byte_index = r.mem_byte_index;
  assign wb_valid = r.wb_valid;
  assign wb_index = r.wb_index;
  assign wb_data = r.wb_data;
  assign exc_valid = r.exc_valid;
  assign exc_code = r.exc_code;

endmodule : unaligned_word_right_load

// [testbench/right_load_asserts.sv]
`timescale 1ns/1ps

module right_load_asserts
  import word_right_load_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic op_valid,
  input wire logic [1:0] op_kind,
  input wire logic [31:0] base_value,
  input wire logic [15:0] imm_offset,
  input wire logic [63:0] dest_old,
  input wire logic core_big_order,
  input wire logic swap_byte_order_flag,
  input wire logic memory_big_order,
  input wire logic extended_user_access_cfg,
  input wire logic release6_core,
  input wire logic [31:0] watch_low_reg,
  input wire logic [31:0] xlat_paddr,
  input wire logic xlat_req,
  input wire logic xlat_is_data,
  input wire logic xlat_user_map,
  input wire logic xlat_done,
  input wire logic [2:0] xlat_seg_mode,
  input wire logic [31:0] mem_word,
  input wire logic op_ready,
  input wire logic [31:0] xlat_virt_addr,
  input wire logic mem_req,
  input wire logic [31:0] mem_paddr,
  input wire logic [1:0] mem_byte_index,
  input wire logic wb_valid,
  input wire logic [63:0] wb_data,
  input wire logic exc_valid,
  input wire logic [3:0] exc_code
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);

  // ------------------------------------------------------------
  // request accepted for a partial-word load on a legacy core
  // ------------------------------------------------------------
  sequence s_take(k);
    op_valid && op_ready && op_kind == k && !release6_core;
  endsequence

  a_plain_ea: assert property (
    s_take(2'h0) |=> xlat_virt_addr == $past(base_value) + {{16{$past(imm_offset[15])}}, $past(imm_offset)})
    else $error("plain load address wrong");
  a_user_cfg: assert property (
    s_take(2'h1) ##0 !extended_user_access_cfg |=> exc_valid && exc_code == EXC_RESERVED_INSN)
    else $error("user load without config not refused");
  a_r6_drop: assert property (
    op_valid && op_ready && op_kind == 2'h0 && release6_core |=> exc_valid && exc_code == EXC_RESERVED_INSN)
    else $error("right load on sixth release not refused");
  a_byte_select: assert property (
    $rose(mem_req) && !release6_core |-> mem_byte_index == (xlat_virt_addr[1:0] ^ {2{core_big_order}}))
    else $error("byte index wrong");
  a_paddr_adjust: assert property (
    $rose(mem_req) && !release6_core |-> mem_paddr == {$past(xlat_paddr[31:2]),
      memory_big_order ? $past(xlat_paddr[1:0]) ^ {2{swap_byte_order_flag}} : 2'b00})
    else $error("physical address adjust wrong");
  a_low_merge: assert property (
    wb_valid |-> wb_data[7:0] == 8'($past(mem_word) >> {mem_byte_index, 3'b000}))
    else $error("low byte merge wrong");
  a_upper_ext: assert property (
    wb_valid && mem_byte_index == 2'h0 |-> wb_data[63:32] == {32{wb_data[31]}})
    else $error("upper bits not sign extended");
  a_upper_keep: assert property (
    wb_valid && mem_byte_index != 2'h0 |-> wb_data[63:32] == dest_old[63:32])
    else $error("upper bits not kept");
  a_watch_data: assert property (
    exc_valid && exc_code == EXC_WATCH |-> watch_low_reg[WATCH_LOAD_BIT])
    else $error("watch fired without data enable");
  a_data_ref: assert property (
    xlat_req |-> xlat_is_data)
    else $error("translation not marked as data reference");
  a_user_map: assert property (
    xlat_user_map |-> $past(xlat_seg_mode) == SEG_MODE_MAPPED_USER_KERNEL && !$past(xlat_done))
    else $error("user mapping outside mapped user kernel segment");
endmodule : right_load_asserts

bind unaligned_word_right_load right_load_asserts i_right_load_asserts (.*);

// [testbench/unaligned_word_right_load_tb.sv]
`timescale 1ns/1ps

module unaligned_word_right_load_tb;
  import word_right_load_pkg::*;
  logic mclk = 1'b0, rst = 1'b1, op_valid = 1'b0, core_big_order = 1'b0;
  logic swap_byte_order_flag = 1'b0, memory_big_order = 1'b0, release6_core = 1'b0;
  logic extended_user_access_cfg = 1'b0, cop0_access_en = 1'b0;
  logic [1:0] op_kind = 2'h0, p_delay = 2'h0;
  logic [31:0] base_value = '0, pc_value = '0, watch_low_reg = '0, p_data = '0;
  logic [15:0] imm_offset = '0;
  logic [18:0] pc_offset = '0;
  logic [4:0] dest_reg_field = '0, wb_index;
  logic [63:0] dest_old = '0, wb_data;
  logic [3:0] p_flt = '0, exc_code;
  logic [2:0] p_seg = '0, xlat_seg_mode;
  logic xlat_done, xlat_refill, xlat_invalid, xlat_addr_err, mem_done, mem_bus_err, op_ready;
  logic xlat_req, xlat_user_map, xlat_is_data, mem_req, wb_valid, exc_valid;
  logic [31:0] xlat_paddr, mem_word, xlat_virt_addr, mem_paddr;
  logic [1:0] mem_byte_index;
  int miscompares = 0, n_checks = 0, cyc = 0;

  unaligned_word_right_load i_unaligned_word_right_load (.*);
  xlat_mem_model i_xlat_mem_model (.*);

  always #4 mclk = ~mclk;

  always @(posedge mclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      miscompares++;
      complete_run;
    end
  end

  task complete_run;
    if (miscompares == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : complete_run

  task chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    n_checks++;
    if (e !== g) begin
      $display("mismatch %s expected %h seen %h", nm, e, g);
      miscompares++;
    end
  endtask : chk

  task rnd;
    @(posedge mclk);
    {base_value, p_data} <= {$urandom, $urandom};
    pc_value <= $urandom & 32'hffff_fffc;
    dest_old <= {$urandom, $urandom};
    {imm_offset, pc_offset, dest_reg_field} <= 40'({$urandom, $urandom});
    {core_big_order, swap_byte_order_flag, memory_big_order, p_delay} <= 5'($urandom);
    watch_low_reg <= $urandom & 32'hffff_fffd;
    {extended_user_access_cfg, cop0_access_en, release6_core, p_flt} <= 7'b110_0000;
    p_seg <= 3'(1 + $urandom % 3);
  endtask : rnd

  // ------------------------------------------------------------
  // issue one op, predict its outcome, compare at completion
  // ------------------------------------------------------------
  task run_op(input logic [1:0] k);
    logic [31:0] va, pa;
    logic [63:0] e;
    logic [1:0] b;
    logic [3:0] ec;
    int n;
    @(posedge mclk);
    op_kind <= k;
    op_valid <= 1'b1;
    @(posedge mclk);
    op_valid <= 1'b0;
    va = (k == 2'h2) ? pc_value + {{11{pc_offset[18]}}, pc_offset, 2'b00} : base_value +
      (k == 2'h1 ? {{23{imm_offset[8]}}, imm_offset[8:0]} : {{16{imm_offset[15]}}, imm_offset});
    b = (k == 2'h2) ? 2'b00 : va[1:0] ^ {2{core_big_order}};
    pa = {~va[31:28], va[27:2], memory_big_order ? va[1:0] ^ {2{swap_byte_order_flag}} : 2'b00};
    for (int i = 0; i < 4; i++) e[8*i+:8] = (i < 4 - b) ? p_data[8*(i+b)+:8] : dest_old[8*i+:8];
    e[63:32] = (b == 2'b00) ? {32{e[31]}} : dest_old[63:32];
    if (k == 2'h3 || release6_core != (k == 2'h2) || (k == 2'h1 && !extended_user_access_cfg))
      ec = EXC_RESERVED_INSN;
    else if (k == 2'h1 && !cop0_access_en) ec = EXC_COP_UNUSABLE;
    else if (p_flt[0]) ec = EXC_TLB_REFILL;
    else if (p_flt[1]) ec = EXC_TLB_INVALID;
    else if (p_flt[2] || (k == 2'h1 && p_seg == 3'h0)) ec = EXC_ADDRESS_ERROR;
    else if (watch_low_reg[1] && va[31:3] == watch_low_reg[31:3]) ec = EXC_WATCH;
    else if (p_flt[3]) ec = EXC_BUS_ERROR;
    else ec = EXC_NONE;
    n = 0;
    #1;
    while (!(wb_valid === 1'b1 || exc_valid === 1'b1) && n < 50) begin
      @(posedge mclk);
      #1;
      n++;
    end
    chk("exc_code", 64'(ec), 64'(exc_valid === 1'b1 ? exc_code : EXC_NONE));
    chk("wb_valid", 64'(ec == EXC_NONE), 64'(wb_valid));
    chk("op_ready", 64'h0000_0000_0000_0001, 64'(op_ready));
    if (ec < EXC_RESERVED_INSN) chk("xlat_virt_addr", 64'(va), 64'(xlat_virt_addr));
    if (ec == EXC_NONE) begin
      chk("wb_data", e, wb_data);
      chk("wb_index", 64'(dest_reg_field), 64'(wb_index));
      if (k != 2'h2) chk("mem_paddr", 64'(pa), 64'(mem_paddr));
      if (k != 2'h2) chk("mem_byte_index", 64'(b), 64'(mem_byte_index));
    end
  endtask : run_op

  initial begin
    void'($urandom(76918));
    repeat (12) @(posedge mclk);
    rst <= 1'b0;
    repeat (40) begin
      rnd;
      run_op(2'h0);
    end
    repeat (20) begin
      rnd;
      run_op(2'h1);
    end
    for (int i = 0; i < 10; i++) begin
      rnd;
      @(posedge mclk);
      case (i)
        0: p_flt <= 4'h3;
        1: p_flt <= 4'h2;
        2: p_flt <= 4'h4;
        3: p_flt <= 4'h8;
        4: p_seg <= 3'h0;
        5: extended_user_access_cfg <= 1'b0;
        6: cop0_access_en <= 1'b0;
        7: release6_core <= 1'b1;
        default: ;
      endcase
      run_op(i > 3 && i < 7 ? 2'h1 : (i == 8 ? 2'h3 : (i == 9 ? 2'h2 : 2'h0)));
    end
    for (int j = 0; j < 4; j++) begin
      rnd;
      @(posedge mclk);
      {imm_offset, pc_offset, release6_core} <= {16'h0000, 19'h0_0000, j[1]};
      watch_low_reg <= ((j[1] ? pc_value : base_value) & 32'hffff_fff8) |
        (j[0] ? 32'h0000_0004 : 32'h0000_0002);
      run_op(j[1] ? 2'h2 : 2'h0);
    end
    complete_run;
  end
endmodule : unaligned_word_right_load_tb

// [testbench/xlat_mem_model.sv]
`timescale 1ns/1ps

module xlat_mem_model (
  input wire logic mclk,
  input wire logic rst,
  input wire logic xlat_req,
  input wire logic [31:0] xlat_virt_addr,
  input wire logic mem_req,
  input wire logic [1:0] p_delay,
  input wire logic [3:0] p_flt,
  input wire logic [2:0] p_seg,
  input wire logic [31:0] p_data,
  output logic xlat_done = 1'b0,
  output logic [31:0] xlat_paddr = 32'h0000_0000,
  output logic [2:0] xlat_seg_mode = 3'h0,
  output logic xlat_refill = 1'b0,
  output logic xlat_invalid = 1'b0,
  output logic xlat_addr_err = 1'b0,
  output logic mem_done = 1'b0,
  output logic [31:0] mem_word = 32'h0000_0000,
  output logic mem_bus_err = 1'b0
);
  logic [1:0] cnt = 2'h0;
  logic busy;
  logic go_x;
  logic go_m;

  assign busy = (xlat_req && !xlat_done) || (mem_req && !mem_done);
  assign go_x = !rst && busy && (cnt == p_delay) && xlat_req;
  assign go_m = !rst && busy && (cnt == p_delay) && !xlat_req;

  // answers carry meaning only with their done strobe, otherwise they toggle
  always @(posedge mclk) begin
    if (rst || !busy) begin
      cnt <= 2'h0;
    end else if (cnt != p_delay) begin
      cnt <= cnt + 2'h1;
    end
    xlat_done <= go_x;
    mem_done <= go_m;
    xlat_paddr <= go_x ? {~xlat_virt_addr[31:28], xlat_virt_addr[27:0]} : ~xlat_paddr;
    xlat_seg_mode <= go_x ? p_seg : ~xlat_seg_mode;
    {xlat_refill, xlat_invalid, xlat_addr_err} <= go_x ? {p_flt[0], p_flt[1], p_flt[2]}
      : ~{xlat_refill, xlat_invalid, xlat_addr_err};
    mem_word <= go_m ? p_data : ~mem_word;
    mem_bus_err <= go_m ? p_flt[3] : ~mem_bus_err;
  end
endmodule : xlat_mem_model
